// File: pkg/btap_pkg.sv
// constants, field layouts and carrier types of the bitstream and tdm audio port
// assumes three importers: the port module in hdl/, and the monitor and the bench in sim/
package btap_pkg;

    // register ids carried in a command field
    localparam logic [6:0] REG_UNUSED_A   = 7'h10;
    localparam logic [6:0] REG_UNUSED_B   = 7'h11;
    localparam logic [6:0] REG_FIR_RESP   = 7'h12;
    localparam logic [6:0] REG_OUT_ENABLE = 7'h13;
    localparam logic [6:0] REG_MODE_CFG   = 7'h14;
    localparam logic [6:0] REG_STREAM_ZF  = 7'h15;
    localparam logic [6:0] REG_ZERO_FLAG  = 7'h16;
    localparam logic [6:0] REG_DEVICE_ID  = 7'h17;
    localparam int         CTL_REGS       = 5;
    localparam logic [7:0] CTL_RESET      = 8'h00;

    // field positions
    localparam int MODE_BIT       = 5;
    localparam int SOFT_RST_BIT   = 6;
    localparam int SPEED_LSB      = 0;
    localparam int FIR_RESP_LSB   = 2;
    localparam int OUT_DIS_BIT    = 4;
    localparam int LEFT_ZERO_BIT  = 1;
    localparam int RIGHT_ZERO_BIT = 2;
    localparam int ZFG_LEFT_BIT   = 0;
    localparam int ZFG_RIGHT_BIT  = 1;

    // writable bits while in bitstream mode
    localparam logic [7:0] BS_MASK_FIR  = 8'h0c;
    localparam logic [7:0] BS_MASK_OUT  = 8'h90;
    localparam logic [7:0] BS_MASK_MODE = 8'h7f;

    // fir speed codes
    localparam logic [1:0] SPEED_FULL    = 2'h0;
    localparam logic [1:0] SPEED_HALF    = 2'h1;
    localparam logic [1:0] SPEED_QUARTER = 2'h3;

    // tdm framing, bit positions counted from the field msb
    localparam logic [4:0] POS_HDR        = 5'h08;
    localparam logic [4:0] POS_REGID      = 5'h0f;
    localparam logic [4:0] POS_OE         = 5'h0f;
    localparam logic [4:0] POS_DATA_FIRST = 5'h10;
    localparam logic [4:0] POS_DATA_LAST  = 5'h17;
    localparam logic [4:0] POS_LAST       = 5'h1f;
    localparam logic [5:0] FIELD_MAX      = 6'h3f;
    localparam logic [2:0] QUAL_WIDTH     = 3'h2;
    localparam logic [2:0] HI_CNT_MAX     = 3'h7;
    localparam logic [4:0] MAX_DEVICE_ID  = 5'h1e;
    localparam logic [4:0] BROADCAST_ID   = 5'h1f;
    localparam logic [4:0] NO_DEVICE_ID   = 5'h00;
    localparam int         ZERO_RUN_DEF   = 1024;

    typedef struct packed {
        logic       id_assign_flag;
        logic       emd;
        logic       dcs;
        logic [4:0] dev_id;
        logic       rd;
        logic [6:0] reg_id;
        logic [7:0] data;
        logic [7:0] unused;
    } btap_cmd_type;

    typedef struct packed {
        logic       tdm_mode;
        logic       bitstream_mode;
        logic [1:0] fir_response;
        logic [1:0] fir_speed;
        logic       output_disable;
    } btap_cfg_type;

    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } btap_audio_type;

    typedef enum logic [1:0] {
        FS_HUNT = 2'b00,
        FS_ONE  = 2'b01,
        FS_TDM  = 2'b10
    } btap_fs_type;

endpackage : btap_pkg

// File: hdl/btap_port.sv
// bitstream input and tdm command/audio port of a stereo converter
// assumes frame sync, serial in and chain in are timed to the tdm bit clock,
// and the bitstream pins are asynchronous to CLK_I
//
// What this block does
// - bitstream mode bit 5 of register 20
// - data, frame sync, sysclk pins carry bitstream
// - two-bit field picks one of four firs
// - speed field sets full, half, quarter rate
// - disabled bits ignored in bitstream mode
// - at most thirty ids, fields counted up to 63
// - two-cycle frame sync pulse means tdm
// - enter after two frames, commands next frame
// - commands in on data, readback three-state
// - chain in tied high gives id one
// - others count fields watching chain in
// - input-chain member only, chains independent
// - id flag frame only assigns ids
// - five-bit id selects chain position
// - sample on rise, drive readback on fall
// - chain out high in last own channel
module btap_port
    import btap_pkg::*;
#(
    parameter int ZERO_RUN = ZERO_RUN_DEF
) (
    // system clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RESET_I,
    // tdm link, clocked by the link bit clock
    input  wire logic        TDM_BCK_I,
    input  wire logic        FRAME_SYNC_I,
    input  wire logic        TDM_SERIAL_IN_I,
    input  wire logic        CHAIN_IN_I,
    output logic             CHAIN_OUT_O,
    output logic             READBACK_O,
    output logic             READBACK_OE_O,
    // bitstream bit clock on the system clock pin
    input  wire logic        BITSTREAM_BIT_CLOCK_I,
    // to the converter core
    output logic             BITSTREAM_MODE_O,
    output logic             TDM_MODE_O,
    output logic [1:0]       FIR_RESPONSE_O,
    output logic             STREAM_LEFT_O,
    output logic             STREAM_RIGHT_O,
    output logic             STREAM_STROBE_O,
    output logic [23:0]      AUDIO_LEFT_O,
    output logic [23:0]      AUDIO_RIGHT_O,
    output logic             AUDIO_VALID_O
);

    localparam int ZW = $clog2(ZERO_RUN) + 1;

    logic           lrst_meta_q, lrst_q;
    logic           fs_prev_q;
    logic [2:0]     hi_cnt_q;
    btap_fs_type    fs_state_q;
    logic           accept_q, did_q, emd_q, seen_q;
    logic [4:0]     pos_q;
    logic [5:0]     field_q, claim_q;
    logic [30:0]    sh_q;
    logic [4:0]     own_id_q;
    logic [7:0]     ctl_q [CTL_REGS];
    logic           rd_pend_q;
    logic [7:0]     rd_sh_q, rd_val;
    logic [1:0]     zf_meta_q, zf_link_q, zero_q;
    btap_audio_type aud_q;
    logic           aud_tgl_q;
    logic           start, fall, qual, last_bit, bs_link, out_dis;
    logic [4:0]     cur_pos;
    logic [5:0]     cur_field, nxt_field, claim_f, own_last;
    btap_cmd_type   word;
    logic           did_now, emd_now, claim_now, have, cmd_field, addr_ok, wr_hit;
    logic           hdr_field, rd_hit;
    btap_cfg_type   cfg_link;

    // reset reaches the link domain through two flops
    always_ff @(posedge TDM_BCK_I) begin
        lrst_meta_q <= RESET_I;
        lrst_q      <= lrst_meta_q;
    end

    assign bs_link   = ctl_q[4][MODE_BIT];
    assign out_dis   = ctl_q[3][OUT_DIS_BIT];
    assign start     = FRAME_SYNC_I & ~fs_prev_q;
    assign fall      = fs_prev_q & ~FRAME_SYNC_I;
    assign cur_pos   = start ? 5'h00 : pos_q;
    assign cur_field = start ? 6'h00 : field_q;
    assign last_bit  = (cur_pos == POS_LAST);
    assign nxt_field = (last_bit && cur_field != FIELD_MAX) ? cur_field + 6'h01 : cur_field;
    assign word      = {sh_q, TDM_SERIAL_IN_I};

    // data sampled on rising bit clock
    always_ff @(posedge TDM_BCK_I) begin
        sh_q  <= word[30:0];
        pos_q <= cur_pos + 5'h01;
        if (lrst_q) begin
            field_q <= FIELD_MAX;
        end else begin
            field_q <= nxt_field;
        end
    end

    // frame sync high time in bit clocks
    always_ff @(posedge TDM_BCK_I) begin
        if (lrst_q) begin
            fs_prev_q <= 1'b0;
            hi_cnt_q  <= 3'h0;
        end else begin
            fs_prev_q <= FRAME_SYNC_I;
            if (start) begin
                hi_cnt_q <= 3'h1;
            end else if (FRAME_SYNC_I && hi_cnt_q != HI_CNT_MAX) begin
                hi_cnt_q <= hi_cnt_q + 3'h1;
            end
        end
    end

    assign qual = fall && (hi_cnt_q == QUAL_WIDTH);

    // two qualifying frames enter tdm mode
    always_ff @(posedge TDM_BCK_I) begin
        if (lrst_q || bs_link) begin
            fs_state_q <= FS_HUNT;
        end else if (fall) begin
            case (fs_state_q)
                FS_HUNT: fs_state_q <= qual ? FS_ONE : FS_HUNT;
                FS_ONE:  fs_state_q <= qual ? FS_TDM : FS_HUNT;
                FS_TDM:  fs_state_q <= qual ? FS_TDM : FS_HUNT;
                default: fs_state_q <= FS_HUNT;
            endcase
        end
    end

    // commands taken from the following frame
    always_ff @(posedge TDM_BCK_I) begin
        if (lrst_q) begin
            accept_q <= 1'b0;
            did_q    <= 1'b0;
            emd_q    <= 1'b0;
        end else if (start) begin
            accept_q <= (fs_state_q == FS_TDM) && !bs_link;
            did_q    <= 1'b0;
            emd_q    <= 1'b0;
        end else if (cur_field == 6'h00 && last_bit) begin
            did_q    <= word.id_assign_flag;
            emd_q    <= word.emd;
        end
    end

    assign did_now = (cur_field == 6'h00 && last_bit) ? word.id_assign_flag : did_q;
    assign emd_now = (cur_field == 6'h00 && last_bit) ? word.emd : emd_q;

    // claim the field after chain in is seen high
    assign claim_now = accept_q && !start && last_bit && CHAIN_IN_I && !seen_q;
    assign claim_f   = claim_now ? nxt_field : claim_q;
    assign have      = (seen_q && !start) || claim_now;
    assign own_last  = did_now ? claim_f : claim_f + 6'h01;

    always_ff @(posedge TDM_BCK_I) begin
        if (lrst_q || start) begin
            seen_q  <= 1'b0;
            claim_q <= 6'h00;
        end else if (claim_now) begin
            seen_q  <= 1'b1;
            claim_q <= nxt_field;
        end
    end

    // tied-high chain in claims field one
    // id frame used only for the id
    always_ff @(posedge TDM_BCK_I) begin
        if (lrst_q) begin
            own_id_q <= NO_DEVICE_ID;
        end else if (claim_now && did_now) begin
            own_id_q <= (claim_f > {1'b0, MAX_DEVICE_ID}) ? MAX_DEVICE_ID : claim_f[4:0];
        end
    end

    // chain out marks the last own field
    always_ff @(posedge TDM_BCK_I) begin
        if (lrst_q) begin
            CHAIN_OUT_O <= 1'b0;
        end else if (start || !accept_q || emd_now) begin
            CHAIN_OUT_O <= 1'b0;
        end else if (out_dis && !did_now) begin
            // skipped device hands the chain on unchanged
            CHAIN_OUT_O <= CHAIN_IN_I;
        end else begin
            CHAIN_OUT_O <= have && (nxt_field == own_last);
        end
    end

    // own audio channels, left then right
    always_ff @(posedge TDM_BCK_I) begin
        if (lrst_q) begin
            aud_q     <= '0;
            aud_tgl_q <= 1'b0;
        end else if (accept_q && !start && last_bit && seen_q && !did_now && !emd_now
                     && !out_dis) begin
            if (cur_field == claim_q) begin
                aud_q.left <= word[31:8];
            end
            if (cur_field == claim_q + 6'h01) begin
                aud_q.right <= word[31:8];
                aud_tgl_q   <= ~aud_tgl_q;
            end
        end
    end

    // commands arrive on the serial data input
    // five-bit id or broadcast selects writes
    assign cmd_field = (cur_field == 6'h00 && !word.id_assign_flag) || (emd_q && cur_field != 6'h00);
    assign addr_ok   = (word.dev_id == own_id_q && own_id_q != NO_DEVICE_ID)
                       || (word.dev_id == BROADCAST_ID);
    assign wr_hit    = accept_q && !start && last_bit && cmd_field && !word.dcs
                       && !word.rd && addr_ok;

    function automatic logic [7:0] wmask(input int idx, input logic bs);
        logic [7:0] m;
        m = 8'hff;
        if (bs) begin
            case (idx)
                2:       m = BS_MASK_FIR;
                3:       m = BS_MASK_OUT;
                4:       m = BS_MASK_MODE;
                default: m = 8'h00;
            endcase
        end
        return m;
    endfunction : wmask

    // mode bit lives in register 20
    // disabled bits keep their value in bitstream mode
    for (genvar g = 0; g < CTL_REGS; g++) begin : g_ctl
        always_ff @(posedge TDM_BCK_I) begin
            if (lrst_q) begin
                ctl_q[g] <= CTL_RESET;
            end else if (wr_hit && word.reg_id == REG_UNUSED_A + 7'(g)) begin
                ctl_q[g] <= (ctl_q[g] & ~wmask(g, bs_link)) | (word.data & wmask(g, bs_link));
            end
        end
    end

    // status flags come from the system domain
    always_ff @(posedge TDM_BCK_I) begin
        zf_meta_q <= {zero_q[1], zero_q[0]};
        zf_link_q <= zf_meta_q;
    end

    always_comb begin
        rd_val = 8'h00;
        case (word[6:0])
            REG_UNUSED_A:   rd_val = ctl_q[0];
            REG_UNUSED_B:   rd_val = ctl_q[1];
            REG_FIR_RESP:   rd_val = ctl_q[2];
            REG_OUT_ENABLE: rd_val = ctl_q[3];
            REG_MODE_CFG:   rd_val = ctl_q[4];
            REG_STREAM_ZF: begin
                rd_val[LEFT_ZERO_BIT]  = zf_link_q[0];
                rd_val[RIGHT_ZERO_BIT] = zf_link_q[1];
            end
            REG_ZERO_FLAG: begin
                rd_val[ZFG_LEFT_BIT]  = zf_link_q[0];
                rd_val[ZFG_RIGHT_BIT] = zf_link_q[1];
            end
            REG_DEVICE_ID:  rd_val = {3'h0, own_id_q};
            default:        rd_val = 8'h00;
        endcase
    end

    // reads need an exact id, never broadcast
    assign hdr_field = (cur_field == 6'h00 && !word[8]) || (emd_q && cur_field != 6'h00);
    assign rd_hit    = accept_q && !start && cur_pos == POS_HDR && hdr_field && !word[6]
                       && word[0] && word[5:1] == own_id_q && own_id_q != NO_DEVICE_ID;

    always_ff @(posedge TDM_BCK_I) begin
        if (lrst_q || start || last_bit) begin
            rd_pend_q <= 1'b0;
        end else if (rd_hit) begin
            rd_pend_q <= 1'b1;
        end
    end

    always_ff @(posedge TDM_BCK_I) begin
        if (lrst_q) begin
            rd_sh_q <= 8'h00;
        end else if (rd_pend_q && cur_pos == POS_REGID) begin
            rd_sh_q <= rd_val;
        end
    end

    // readback driven on the falling edge
    // enable opens one bit before the data
    always_ff @(negedge TDM_BCK_I) begin
        if (lrst_q) begin
            READBACK_OE_O <= 1'b0;
            READBACK_O    <= 1'b0;
        end else begin
            READBACK_OE_O <= rd_pend_q && pos_q >= POS_OE && pos_q <= POS_DATA_LAST;
            READBACK_O    <= rd_pend_q && pos_q >= POS_DATA_FIRST && pos_q <= POS_DATA_LAST
                             && rd_sh_q[~pos_q[2:0]];
        end
    end

    // system clock domain; settings are quasi-static, so a level sync suffices
    assign cfg_link = '{tdm_mode: fs_state_q == FS_TDM, bitstream_mode: bs_link,
                        fir_response: ctl_q[2][FIR_RESP_LSB +: 2],
                        fir_speed: ctl_q[4][SPEED_LSB +: 2], output_disable: out_dis};

    btap_cfg_type cfg_meta_q, cfg_q;
    logic [2:0]   pin_meta_q, pin_q;
    logic         bitstream_bit_clock_prev_q, rise;
    logic [1:0]   div_q, div_lim;
    logic [2:0]   tg_q;

    always_ff @(posedge CLK_I) begin
        cfg_meta_q <= cfg_link;
        cfg_q      <= cfg_meta_q;
    end

    // data pin left, sync pin right, sysclk bit clock
    always_ff @(posedge CLK_I) begin
        pin_meta_q <= {FRAME_SYNC_I, TDM_SERIAL_IN_I, BITSTREAM_BIT_CLOCK_I};
        pin_q      <= pin_meta_q;
    end

    assign rise = pin_q[0] && !bitstream_bit_clock_prev_q && cfg_q.bitstream_mode;

    // reserved speed code runs at full rate
    always_comb begin
        case (cfg_q.fir_speed)
            SPEED_HALF:    div_lim = 2'h1;
            SPEED_QUARTER: div_lim = 2'h3;
            default:       div_lim = 2'h0;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            bitstream_bit_clock_prev_q     <= 1'b0;
            div_q           <= 2'h0;
            STREAM_LEFT_O   <= 1'b0;
            STREAM_RIGHT_O  <= 1'b0;
            STREAM_STROBE_O <= 1'b0;
        end else begin
            bitstream_bit_clock_prev_q     <= pin_q[0];
            STREAM_STROBE_O <= rise && div_q == div_lim;
            if (rise) begin
                div_q          <= (div_q == div_lim) ? 2'h0 : div_q + 2'h1;
                STREAM_LEFT_O  <= pin_q[1];
                STREAM_RIGHT_O <= pin_q[2];
            end
        end
    end

    // a stream stuck at one level for the run length counts as zero
    for (genvar c = 0; c < 2; c++) begin : g_zero
        logic [ZW-1:0] run_q;
        logic          last_q;
        always_ff @(posedge CLK_I) begin
            if (RESET_I || !cfg_q.bitstream_mode) begin
                run_q     <= '0;
                last_q    <= 1'b0;
                zero_q[c] <= 1'b0;
            end else if (rise) begin
                last_q    <= pin_q[c + 1];
                if (pin_q[c + 1] != last_q) begin
                    run_q <= '0;
                end else if (run_q != ZW'(ZERO_RUN)) begin
                    run_q <= run_q + 1'b1;
                end
                zero_q[c] <= (pin_q[c + 1] == last_q) && run_q >= ZW'(ZERO_RUN - 1);
            end
        end
    end

    // fir response reaches the core in bitstream mode
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            BITSTREAM_MODE_O <= 1'b0;
            TDM_MODE_O       <= 1'b0;
            FIR_RESPONSE_O   <= 2'h0;
        end else begin
            BITSTREAM_MODE_O <= cfg_q.bitstream_mode;
            TDM_MODE_O       <= cfg_q.tdm_mode;
            FIR_RESPONSE_O   <= cfg_q.bitstream_mode ? cfg_q.fir_response : 2'h0;
        end
    end

    // audio pair handed over by toggle; words stay still for a frame
    always_ff @(posedge CLK_I) begin
        if (RESET_I) begin
            tg_q          <= 3'h0;
            AUDIO_LEFT_O  <= 24'h000000;
            AUDIO_RIGHT_O <= 24'h000000;
            AUDIO_VALID_O <= 1'b0;
        end else begin
            tg_q          <= {tg_q[1:0], aud_tgl_q};
            AUDIO_VALID_O <= tg_q[2] ^ tg_q[1];
            if (tg_q[2] ^ tg_q[1]) begin
                AUDIO_LEFT_O  <= aud_q.left;
                AUDIO_RIGHT_O <= aud_q.right;
            end
        end
    end

endmodule : btap_port

// File: sim/btap_port_monitor.sv
// concurrent checks on the pins of btap_port
// assumes bind into btap_port; link logic runs on TDM_BCK_I
module btap_port_monitor
    import btap_pkg::*;
#(
    parameter int ZERO_RUN = ZERO_RUN_DEF
) (
    // clocks and reset
    input wire logic       CLK_I,
    input wire logic       RESET_I,
    input wire logic       TDM_BCK_I,
    // link side
    input wire logic       CHAIN_OUT_O,
    input wire logic       READBACK_O,
    input wire logic       READBACK_OE_O,
    // core side
    input wire logic       BITSTREAM_MODE_O,
    input wire logic       TDM_MODE_O,
    input wire logic [1:0] FIR_RESPONSE_O,
    input wire logic       STREAM_STROBE_O,
    input wire logic       AUDIO_VALID_O
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [5:0] hi_cnt_q;

    // run length of chain out, wraps harmlessly when it stays high
    always_ff @(posedge TDM_BCK_I) begin
        if (RESET_I) begin
            hi_cnt_q <= 6'h00;
        end else begin
            hi_cnt_q <= CHAIN_OUT_O ? hi_cnt_q + 6'h01 : 6'h00;
        end
    end

    a_audio_in_tdm: assert property (@(posedge CLK_I) disable iff (RESET_I)
        AUDIO_VALID_O |-> TDM_MODE_O ##1 !AUDIO_VALID_O) else $error("bad audio valid");
    a_strobe_mode: assert property (@(posedge CLK_I) disable iff (RESET_I)
        STREAM_STROBE_O |-> BITSTREAM_MODE_O ##1 !STREAM_STROBE_O) else $error("bad strobe");
    a_mode_sticky: assert property (@(posedge CLK_I) disable iff (RESET_I)
        BITSTREAM_MODE_O |=> BITSTREAM_MODE_O) else $error("bitstream mode dropped");
    a_fir_idle: assert property (@(posedge CLK_I) disable iff (RESET_I)
        !BITSTREAM_MODE_O |-> FIR_RESPONSE_O == 2'h0) else $error("fir code outside mode");
    a_fir_hold: assert property (@(posedge CLK_I) disable iff (RESET_I)
        BITSTREAM_MODE_O && $past(BITSTREAM_MODE_O, 8) |-> $stable(FIR_RESPONSE_O))
        else $error("fir code moved");
    a_oe_span: assert property (@(posedge TDM_BCK_I) disable iff (RESET_I)
        $rose(READBACK_OE_O) |=> READBACK_OE_O [*8] ##1 !READBACK_OE_O)
        else $error("readback enable span wrong");
    a_oe_lead: assert property (@(posedge TDM_BCK_I) disable iff (RESET_I)
        $rose(READBACK_OE_O) |-> !READBACK_O) else $error("early readback bit not low");
    a_oe_in_tdm: assert property (@(posedge TDM_BCK_I) disable iff (RESET_I)
        READBACK_OE_O |-> TDM_MODE_O) else $error("readback outside tdm");
    a_chain_field: assert property (@(posedge TDM_BCK_I) disable iff (RESET_I)
        $fell(CHAIN_OUT_O) |-> hi_cnt_q == 6'h20) else $error("chain out not one field");

    c_tdm: cover property (@(posedge CLK_I) $rose(TDM_MODE_O));
    c_audio: cover property (@(posedge CLK_I) AUDIO_VALID_O);
    c_read: cover property (@(posedge TDM_BCK_I) $rose(READBACK_OE_O));
    c_bits: cover property (@(posedge CLK_I) $rose(BITSTREAM_MODE_O));
endmodule : btap_port_monitor

bind btap_port btap_port_monitor #(.ZERO_RUN(ZERO_RUN)) btap_port_monitor_inst (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .TDM_BCK_I(TDM_BCK_I), .CHAIN_OUT_O(CHAIN_OUT_O),
    .READBACK_O(READBACK_O), .READBACK_OE_O(READBACK_OE_O), .TDM_MODE_O(TDM_MODE_O),
    .BITSTREAM_MODE_O(BITSTREAM_MODE_O), .FIR_RESPONSE_O(FIR_RESPONSE_O),
    .STREAM_STROBE_O(STREAM_STROBE_O), .AUDIO_VALID_O(AUDIO_VALID_O)
);

// File: sim/btap_host_model.sv
// host side of the link: tdm frame source and bitstream source
// assumes one btap_port opposite and an 80 ns link bit clock
module btap_host_model (
    // link outputs
    output logic      bck_o,
    output logic      sync_o,
    output logic      sdi_o,
    output logic      bs_clk_o,
    // device answers
    input wire logic  chain_out_i,
    input wire logic  readback_i,
    input wire logic  readback_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0]  rd_byte;
    logic [0:95] chain_log;

    initial begin
        {bck_o, sync_o, sdi_o, bs_clk_o} = 4'h0;
        rd_byte = 8'h00;
        chain_log = '0;
    end

    // clock only for the reset sequence, frames make their own
    task automatic idle_clocks(input int n);
        repeat (n) begin
            #40 bck_o = 1'b1;
            #40 bck_o = 1'b0;
        end
    endtask : idle_clocks

    task automatic send(input logic [95:0] bits, input int nf, input int sw);
        for (int r = 0; r < 32 * nf; r++) begin
            sdi_o = bits[95 - r];
            sync_o = (r < sw);
            #40 bck_o = 1'b1;
            chain_log[r] = chain_out_i;
            if (r >= 16 && r < 24) rd_byte[23 - r] = readback_oe_i ? readback_i : r[0];
            #40 bck_o = 1'b0;
        end
    endtask : send

    // streams on data and sync pins
    // bit clock runs only while streaming
    task automatic stream(input logic l, input logic rt, input int n);
        repeat (n) begin
            sdi_o = l;
            sync_o = rt;
            #48 bs_clk_o = 1'b1;
            #48 bs_clk_o = 1'b0;
        end
    endtask : stream
endmodule : btap_host_model

// File: sim/btap_port_tb_top.sv
// self-checking bench for btap_port with the host model on the link
// assumes btap_pkg, the monitor bind and the host model compiled first
module btap_port_tb_top
    import btap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic       dcs;
        logic [4:0] id;
        logic [6:0] rg;
        logic [7:0] wd;
        logic [7:0] ex;
    } btap_row_type;

    logic        clk, rst, chain_in, counting;
    logic        bck, sync, sdi, bs_clk, chain_out, rb, rb_oe;
    logic        bs_mode, tdm_mode, s_left, s_right, strobe, a_valid;
    logic [1:0]  fir;
    logic [23:0] a_left, a_right, cap_l, cap_r;
    int          n_fail, checks_done, n_valid, n_strobe;
    int          sw_list[4] = '{1, 16, 2, 3};
    int          div[4] = '{16, 8, 4, 16};
    logic [1:0]  spd[4] = '{SPEED_FULL, SPEED_HALF, SPEED_QUARTER, 2'h2};
    btap_row_type rows[9] = '{
        '{1'b0, 5'h00, 7'h12, 8'h11, 8'h00}, '{1'b0, 5'h01, 7'h12, 8'ha5, 8'ha5},
        '{1'b1, 5'h01, 7'h12, 8'h3c, 8'ha5}, '{1'b0, 5'h02, 7'h12, 8'h3c, 8'ha5},
        '{1'b0, 5'h1f, 7'h10, 8'h5a, 8'h5a}, '{1'b0, 5'h01, 7'h15, 8'hff, 8'h00},
        '{1'b0, 5'h01, 7'h17, 8'hff, 8'h01}, '{1'b0, 5'h01, 7'h33, 8'h77, 8'h00},
        '{1'b0, 5'h01, 7'h14, 8'h03, 8'h03}};

    btap_port #(.ZERO_RUN(8)) btap_port_inst (
        .CLK_I(clk), .RESET_I(rst), .TDM_BCK_I(bck), .FRAME_SYNC_I(sync),
        .TDM_SERIAL_IN_I(sdi), .CHAIN_IN_I(chain_in), .CHAIN_OUT_O(chain_out),
        .READBACK_O(rb), .READBACK_OE_O(rb_oe), .BITSTREAM_BIT_CLOCK_I(bs_clk),
        .BITSTREAM_MODE_O(bs_mode), .TDM_MODE_O(tdm_mode), .FIR_RESPONSE_O(fir),
        .STREAM_LEFT_O(s_left), .STREAM_RIGHT_O(s_right), .STREAM_STROBE_O(strobe),
        .AUDIO_LEFT_O(a_left), .AUDIO_RIGHT_O(a_right), .AUDIO_VALID_O(a_valid));

    btap_host_model host_inst (
        .bck_o(bck), .sync_o(sync), .sdi_o(sdi), .bs_clk_o(bs_clk),
        .chain_out_i(chain_out), .readback_i(rb), .readback_oe_i(rb_oe));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(negedge clk) begin
        if (a_valid === 1'b1) begin
            n_valid++;
            cap_l = a_left;
            cap_r = a_right;
        end
        if (counting && strobe === 1'b1) n_strobe++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done

    function automatic logic [31:0] cmd(input logic dcs, input logic [4:0] id,
                                        input logic rd, input logic [6:0] rg,
                                        input logic [7:0] dt);
        btap_cmd_type c;
        c = '{id_assign_flag: 1'b0, emd: 1'b0, dcs: dcs, dev_id: id, rd: rd, reg_id: rg,
              data: dt, unused: 8'h00};
        return c;
    endfunction : cmd

    // link domain takes reset only with its clock running
    task automatic do_reset;
        @(negedge clk);
        rst = 1'b1;
        repeat (16) @(negedge clk);
        host_inst.idle_clocks(4);
        @(negedge clk);
        rst = 1'b0;
        host_inst.idle_clocks(4);
    endtask : do_reset

    task automatic fr(input logic [31:0] f0);
        host_inst.send({f0, 64'h0}, 1, 2);
    endtask : fr

    initial begin
        rst = 1'b1;
        counting = 1'b0;
        chain_in = 1'b1;
        do_reset;
        check(32'({bs_mode, tdm_mode, chain_out, rb_oe, a_valid, strobe}), 32'h0);
        foreach (sw_list[i]) host_inst.send(96'h0, 1, sw_list[i]);
        fr(cmd(1'b0, BROADCAST_ID, 1'b0, REG_FIR_RESP, 8'hff));
        repeat (20) @(negedge clk);
        check(32'(tdm_mode), 32'h0);
        fr(32'h0);
        repeat (20) @(negedge clk);
        check(32'(tdm_mode), 32'h1);
        host_inst.send({32'h8000_0000, 64'h0}, 3, 2);
        check(32'(host_inst.chain_log[48]), 32'h1);
        check(32'(host_inst.chain_log[80]), 32'h0);
        $display("test detect and id done");
        foreach (rows[i]) begin
            fr(cmd(rows[i].dcs, rows[i].id, 1'b0, rows[i].rg, rows[i].wd));
            fr(cmd(1'b0, 5'h01, 1'b1, rows[i].rg, 8'h00));
            check(32'(host_inst.rd_byte), 32'(rows[i].ex));
        end
        $display("test register rows done");
        n_valid = 0;
        host_inst.send({32'h0, 32'h1234_5600, 32'habcd_ef00}, 3, 2);
        repeat (20) @(negedge clk);
        check(32'(n_valid), 32'h1);
        check({8'h0, cap_l}, 32'h0012_3456);
        check({8'h0, cap_r}, 32'h00ab_cdef);
        check(32'(host_inst.chain_log[80]), 32'h1);
        check(32'(host_inst.chain_log[48]), 32'h0);
        $display("test audio done");
        for (int k = 0; k < 4; k++) begin
            do_reset;
            fr(32'h0);
            fr(32'h0);
            fr(cmd(1'b0, BROADCAST_ID, 1'b0, REG_FIR_RESP, 8'(k << 2)));
            fr(cmd(1'b0, BROADCAST_ID, 1'b0, REG_MODE_CFG, {6'h00, spd[k]}));
            fr(cmd(1'b0, BROADCAST_ID, 1'b0, REG_MODE_CFG, {6'h08, spd[k]}));
            n_strobe = 0;
            fork
                host_inst.stream(1'b1, 1'b0, 24);
                begin
                    repeat (4) @(posedge bs_clk);
                    counting = 1'b1;
                    repeat (16) @(posedge bs_clk);
                    counting = 1'b0;
                end
            join
            check(32'(bs_mode), 32'h1);
            check(32'(fir), 32'(k));
            check(32'(n_strobe), 32'(div[k]));
            check(32'({s_left, s_right}), 32'h2);
        end
        $display("test bitstream done");
        test_done;
    end

    initial begin
        #300us;
        n_fail++;
        $display("watchdog expired");
        test_done;
    end
endmodule : btap_port_tb_top
